// ===== hdl/dig_in_pkg.sv
// Shared constants for the digital input group and its AXI4-Lite register map
package dig_in_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_LEVEL = 8'h04;
  localparam logic [7:0] OFF_HIST = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_OUT = 8'h10;
  // Command codes, written to OFF_CMD
  localparam logic [3:0] CMD_READ_LEVEL = 4'h1;
  localparam logic [3:0] CMD_READ_HIST = 4'h2;
  localparam logic [3:0] CMD_READ_HIST_CLR = 4'h3;
  localparam logic [3:0] CMD_ARM_TRANS = 4'h4;
  localparam logic [3:0] CMD_ARM_SYNC = 4'h5;
  localparam logic [3:0] CMD_TEST_ONES = 4'h6;
  localparam logic [3:0] CMD_TEST_ZEROS = 4'h7;
  localparam logic [3:0] CMD_DEV_RESET = 4'h8;
  localparam logic [3:0] CMD_HALT = 4'h9;
  localparam logic [3:0] CMD_WRITE_OUT = 4'hA;
  // Status bit positions
  localparam int ST_MODE_LO = 0;
  localparam int ST_IRQ = 2;
  localparam int ST_BUSY = 3;
  localparam int ST_DIAG = 4;
  localparam int ST_READY = 5;
  localparam int ST_FROZEN = 6;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // Timing, clock period in ns
  localparam int CLK_NS = 8;
  localparam int OUT_VALID_NS = 2000;
  localparam int RDY_MIN_NS = 500;
  localparam int RDY_MAX_NS = 1000;
  localparam int IRQ_MAX_NS = 9000;
  // Outputs valid: longest time, round down
  localparam int OUT_VALID_CYC = OUT_VALID_NS / CLK_NS;
  // Ready lag: least rounded up, must stay below max rounded down
  localparam int RDY_LAG_CYC = (RDY_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int RDY_MAX_CYC = RDY_MAX_NS / CLK_NS;
  localparam int IRQ_MAX_CYC = IRQ_MAX_NS / CLK_NS;
  // Reset values
  localparam logic [15:0] RST_WORD = 16'h0000;
  // Mode enumeration, Gray along idle -> trans -> sync
  typedef enum logic [1:0] {
    MODE_PLAIN = 2'b00,
    MODE_TRANS = 2'b01,
    MODE_SYNC = 2'b11
  } mode_t;
endpackage

// ===== hdl/dig_in_group.sv
// Sixteen-point digital input group with sync handshake, self-test and output point port
//
// Added by the designer: the address map and the AXI4-Lite register port.
`timescale 1ns/1ns
// -----------------------------------------------------------------
// -----------------------------------------------------------------
module dig_in_group #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input wire logic SYS_CLK_IN,
  input wire logic RST_IN,
  // AXI4-Lite write address and data
  input wire logic [7:0] S_AXI_AWADDR_IN,
  input wire logic S_AXI_AWVALID_IN,
  output logic S_AXI_AWREADY_OUT,
  input wire logic [31:0] S_AXI_WDATA_IN,
  input wire logic [3:0] S_AXI_WSTRB_IN,
  input wire logic S_AXI_WVALID_IN,
  output logic S_AXI_WREADY_OUT,
  // AXI4-Lite write response
  output logic [1:0] S_AXI_BRESP_OUT,
  output logic S_AXI_BVALID_OUT,
  input wire logic S_AXI_BREADY_IN,
  // AXI4-Lite read
  input wire logic [7:0] S_AXI_ARADDR_IN,
  input wire logic S_AXI_ARVALID_IN,
  output logic S_AXI_ARREADY_OUT,
  output logic [31:0] S_AXI_RDATA_OUT,
  output logic [1:0] S_AXI_RRESP_OUT,
  output logic S_AXI_RVALID_OUT,
  input wire logic S_AXI_RREADY_IN,
  // User pins
  input wire logic [WIDTH-1:0] LEVEL_INPUT_IN,
  input wire logic SYNC_STROBE_IN,
  output logic READY_OUT,
  output logic [WIDTH-1:0] OUT_POINTS_OUT,
  output logic OUT_READY_OUT,
  // Interrupt request toward the channel
  output logic IRQ_OUT
);

  // Whole state in one struct
  typedef struct packed {
    logic [WIDTH-1:0] s1, s2, s3;   // Pin synchroniser
    logic [WIDTH-1:0] flt;          // Filtered input
    logic y1, y2, y3, yflt;         // Sync pin synchroniser
    logic [WIDTH-1:0] eff_prev;     // Previous effective sample
    logic sync_prev;
    logic [WIDTH-1:0] level;        // Level register
    logic frozen;
    logic [WIDTH-1:0] trans;        // Transition latch
    dig_in_pkg::mode_t mode;
    logic sync_irq;
    logic diag;
    logic diag_val;
    logic diag_pulse;               // Forced sync receiver pulse
    logic ready;
    logic busy;
    logic [WIDTH-1:0] out_q;
    logic [WIDTH-1:0] out_pts;
    logic [11:0] out_cnt;
    logic out_rdy;
    logic irq;
    logic awr, wr, bval, arr, rval;
    logic [7:0] awa;
    logic [31:0] wd;
    logic wr_got_a, wr_got_d;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
  } state_t;

  state_t st_ff, nxt_st;

  // Combinational effective inputs after diagnostic forcing
  logic [WIDTH-1:0] eff, rise;
  logic eff_sync, sync_rise;
  logic wr_fire, rd_fire;
  logic [3:0] cmd;
  logic pending;

  always_comb
  begin
    nxt_st = st_ff;
    // three-stage sync, change when stages two and three agree
    nxt_st.s1 = LEVEL_INPUT_IN;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    nxt_st.flt = (st_ff.s2 & st_ff.s3) | (st_ff.flt & (st_ff.s2 | st_ff.s3));
    nxt_st.y1 = SYNC_STROBE_IN;
    nxt_st.y2 = st_ff.y1;
    nxt_st.y3 = st_ff.y2;
    nxt_st.yflt = (st_ff.y2 == st_ff.y3) ? st_ff.y3 : st_ff.yflt;
    // user inputs disabled, receivers forced in diagnostic
    // forced values flow through the normal path
    eff = st_ff.diag ? {WIDTH{st_ff.diag_val}} : st_ff.flt;
    eff_sync = st_ff.diag ? st_ff.diag_pulse : st_ff.yflt;
    nxt_st.diag_pulse = 1'b0;
    rise = eff & ~st_ff.eff_prev;
    sync_rise = eff_sync & ~st_ff.sync_prev;
    nxt_st.eff_prev = eff;
    nxt_st.sync_prev = eff_sync;
    // level register follows inputs unless frozen
    nxt_st.level = st_ff.frozen ? st_ff.level : eff;
    // record first rising edge per point
    nxt_st.trans = st_ff.trans | rise;
    // sync edge freezes, drops ready, posts interrupt
    if (st_ff.mode == dig_in_pkg::MODE_SYNC && st_ff.ready && sync_rise)
    begin
      nxt_st.frozen = 1'b1;
      nxt_st.ready = 1'b0;
      nxt_st.sync_irq = 1'b1;
    end
    // points follow next cycle; counter first so a write restarts it
    nxt_st.out_pts = st_ff.out_q;
    nxt_st.out_cnt = (st_ff.out_cnt < 12'(dig_in_pkg::RDY_LAG_CYC)) ? st_ff.out_cnt + 12'h0001
      : st_ff.out_cnt;
    nxt_st.out_rdy = st_ff.out_rdy || (st_ff.out_cnt >= 12'(dig_in_pkg::RDY_LAG_CYC));
    // AXI handshake bookkeeping, ready pulses once per item
    nxt_st.awr = S_AXI_AWVALID_IN && !st_ff.wr_got_a && !st_ff.bval && !st_ff.awr;
    nxt_st.wr = S_AXI_WVALID_IN && !st_ff.wr_got_d && !st_ff.bval && !st_ff.wr;
    if (st_ff.awr && S_AXI_AWVALID_IN)
    begin
      nxt_st.wr_got_a = 1'b1;
      nxt_st.awa = S_AXI_AWADDR_IN;
    end
    if (st_ff.wr && S_AXI_WVALID_IN)
    begin
      nxt_st.wr_got_d = 1'b1;
      nxt_st.wd = S_AXI_WDATA_IN;
    end
    wr_fire = st_ff.wr_got_a && st_ff.wr_got_d && !st_ff.bval;
    cmd = st_ff.wd[3:0];
    // transition interrupt is OR of the latch when armed
    // any pending interrupt makes commands other than halt, device reset and the servicing read answer busy
    pending = st_ff.sync_irq || (st_ff.mode == dig_in_pkg::MODE_TRANS && |st_ff.trans);
    nxt_st.bval = st_ff.bval && !S_AXI_BREADY_IN;
    if (wr_fire)
    begin
      nxt_st.wr_got_a = 1'b0;
      nxt_st.wr_got_d = 1'b0;
      nxt_st.bval = 1'b1;
      nxt_st.bresp = dig_in_pkg::RESP_OKAY;
      nxt_st.busy = 1'b0;
      if (st_ff.awa == dig_in_pkg::OFF_OUT)
      begin
        // one turns a point on; output ready restarts
        nxt_st.out_q = st_ff.wd[WIDTH-1:0];
        nxt_st.out_cnt = 12'h0000;
        nxt_st.out_rdy = 1'b0;
      end
      else if (st_ff.awa != dig_in_pkg::OFF_CMD)
      begin
        nxt_st.bresp = dig_in_pkg::RESP_SLVERR;
      end
      else if (cmd == dig_in_pkg::CMD_DEV_RESET || cmd == dig_in_pkg::CMD_HALT)
      begin
        // halt or device reset leaves sync mode
        nxt_st.mode = dig_in_pkg::MODE_PLAIN;
        nxt_st.frozen = 1'b0;
        nxt_st.ready = 1'b0;
        nxt_st.sync_irq = 1'b0;
        nxt_st.diag = 1'b0;
        nxt_st.trans = (cmd == dig_in_pkg::CMD_DEV_RESET) ? rise : nxt_st.trans;
      end
      else if (pending)
      begin
        nxt_st.busy = 1'b1;
        nxt_st.bresp = dig_in_pkg::RESP_SLVERR;
        if (cmd == dig_in_pkg::CMD_READ_HIST_CLR)
        begin
          // Clearing read is the service action for a transition interrupt
          nxt_st.busy = st_ff.sync_irq;
          nxt_st.bresp = st_ff.sync_irq ? dig_in_pkg::RESP_SLVERR : dig_in_pkg::RESP_OKAY;
          // latch cleared at end of command, new edges still win
          nxt_st.trans = st_ff.sync_irq ? nxt_st.trans : rise;
        end
        else if (cmd == dig_in_pkg::CMD_READ_LEVEL && st_ff.sync_irq)
        begin
          // servicing read releases register, raises ready
          nxt_st.busy = 1'b0;
          nxt_st.bresp = dig_in_pkg::RESP_OKAY;
          nxt_st.sync_irq = 1'b0;
          nxt_st.frozen = 1'b0;
          nxt_st.ready = 1'b1;
        end
      end
      else
      begin
        case (cmd)
          dig_in_pkg::CMD_ARM_TRANS:
          begin
            // arm leaves sync; arm clears latch
            nxt_st.mode = dig_in_pkg::MODE_TRANS;
            nxt_st.ready = 1'b0;
            nxt_st.frozen = 1'b0;
            nxt_st.trans = rise;
          end
          dig_in_pkg::CMD_ARM_SYNC:
          begin
            nxt_st.mode = dig_in_pkg::MODE_SYNC;
            nxt_st.ready = 1'b1;
            nxt_st.frozen = 1'b0;
          end
          dig_in_pkg::CMD_TEST_ONES, dig_in_pkg::CMD_TEST_ZEROS:
          begin
            // force receivers and pulse sync once
            nxt_st.diag = 1'b1;
            nxt_st.diag_val = (cmd == dig_in_pkg::CMD_TEST_ONES);
            nxt_st.diag_pulse = 1'b1;
          end
          dig_in_pkg::CMD_READ_HIST_CLR:
          begin
            nxt_st.trans = rise;
          end
          default:
          begin
            // Plain reads change nothing; history stays set
            nxt_st.busy = 1'b0;
          end
        endcase
      end
    end
    // Read channel: one cycle to answer
    nxt_st.arr = S_AXI_ARVALID_IN && !st_ff.rval && !st_ff.arr;
    // Response stands until the master takes it
    nxt_st.rval = st_ff.rval && !S_AXI_RREADY_IN;
    rd_fire = st_ff.arr && S_AXI_ARVALID_IN;
    if (rd_fire)
    begin
      nxt_st.rval = 1'b1;
      nxt_st.rresp = dig_in_pkg::RESP_OKAY;
      case (S_AXI_ARADDR_IN)
        dig_in_pkg::OFF_LEVEL: nxt_st.rdata = 32'(st_ff.level);
        dig_in_pkg::OFF_HIST: nxt_st.rdata = 32'(st_ff.trans);
        dig_in_pkg::OFF_STATUS: nxt_st.rdata = 32'({st_ff.frozen, st_ff.ready, st_ff.diag,
          st_ff.busy, st_ff.irq, st_ff.mode});
        dig_in_pkg::OFF_OUT: nxt_st.rdata = 32'(st_ff.out_q);
        default:
        begin
          nxt_st.rdata = 32'h0000_0000;
          nxt_st.rresp = dig_in_pkg::RESP_SLVERR;
        end
      endcase
    end
    // interrupt raised the cycle after the latch is set
    // well inside the nine microsecond bound
    nxt_st.irq = pending;
    if (RST_IN)
    begin
      nxt_st = '0;
      nxt_st.mode = dig_in_pkg::MODE_PLAIN;
      nxt_st.out_cnt = 12'(dig_in_pkg::RDY_LAG_CYC);
    end
  end

  // Single state register
  always_ff @(posedge SYS_CLK_IN)
  begin
    st_ff <= nxt_st;
  end

  // Ports straight from flops
  assign S_AXI_AWREADY_OUT = st_ff.awr;
  assign S_AXI_WREADY_OUT = st_ff.wr;
  assign S_AXI_BVALID_OUT = st_ff.bval;
  assign S_AXI_BRESP_OUT = st_ff.bresp;
  assign S_AXI_ARREADY_OUT = st_ff.arr;
  assign S_AXI_RVALID_OUT = st_ff.rval;
  assign S_AXI_RDATA_OUT = st_ff.rdata;
  assign S_AXI_RRESP_OUT = st_ff.rresp;
  assign READY_OUT = st_ff.ready;
  assign OUT_POINTS_OUT = st_ff.out_pts;
  assign OUT_READY_OUT = st_ff.out_rdy;
  assign IRQ_OUT = st_ff.irq;

  // Checks
  // Sync edge: handshake drops and level holds, interrupt one cycle later
  sequence seq_freeze_irq;
    (!READY_OUT && st_ff.frozen) ##1 IRQ_OUT;
  endsequence
  chk_irq_or: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    (st_ff.mode == dig_in_pkg::MODE_TRANS && |st_ff.trans && !st_ff.sync_irq) |=> IRQ_OUT)
    else $error("irq not raised from latch");
  chk_latch_hold: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    (|(st_ff.trans) && !wr_fire) |=> ((st_ff.trans & $past(st_ff.trans)) == $past(st_ff.trans)))
    else $error("latch bit lost");
  chk_sync_freeze: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    (st_ff.mode == dig_in_pkg::MODE_SYNC && st_ff.ready && sync_rise && !wr_fire)
    |=> seq_freeze_irq)
    else $error("sync edge not handled");
  chk_frozen_level: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    st_ff.frozen && !wr_fire |=> $stable(st_ff.level))
    else $error("frozen level moved");
  chk_arm_sync: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    (wr_fire && !pending && st_ff.awa == dig_in_pkg::OFF_CMD
     && cmd == dig_in_pkg::CMD_ARM_SYNC) |=> READY_OUT)
    else $error("arm sync no ready");
  chk_busy_refuse: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    (wr_fire && st_ff.sync_irq && st_ff.awa == dig_in_pkg::OFF_CMD
     && cmd == dig_in_pkg::CMD_ARM_SYNC) |=> (st_ff.busy && st_ff.mode == $past(st_ff.mode)))
    else $error("busy not returned");
  chk_out_ready: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    (wr_fire && st_ff.awa == dig_in_pkg::OFF_OUT) |=> !OUT_READY_OUT [*8])
    else $error("out ready too early");
  chk_out_ready_max: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    !$stable(st_ff.out_pts) |-> ##[1:125] OUT_READY_OUT)
    else $error("out ready too late");
  chk_diag_force: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    st_ff.diag && !st_ff.frozen && $past(st_ff.diag) |=> st_ff.level == {WIDTH{$past(st_ff.diag_val)}})
    else $error("diag not forcing");
  chk_point_on: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    (wr_fire && st_ff.awa == dig_in_pkg::OFF_OUT) |=> ##1 OUT_POINTS_OUT == $past(st_ff.wd[WIDTH-1:0], 2))
    else $error("output points wrong");
endmodule

// ===== sim/ext_equip.sv
// Model of the user's equipment driving points and sync strobe
`timescale 1ns/1ns
module ext_equip #(
  parameter int DESKEW = 130
) (
  // Clock and handshake
  input wire logic clk_in,
  input wire logic ready_in,
  // Toward the group
  output logic [15:0] level_out,
  output logic sync_out
);
  // Idle: points and strobe low
  initial
  begin
    level_out = 16'h0000;
    sync_out = 1'b0;
  end
  // New point value after next edge
  task automatic put(input logic [15:0] v);
    @(posedge clk_in);
    level_out <= v;
  endtask
  // One sync transfer, only once the group is ready
  task automatic send(input logic [15:0] v);
    while (ready_in !== 1'b1) @(posedge clk_in);
    put(v);
    // Points stay put around the strobe, else data is garbage
    repeat (DESKEW) @(posedge clk_in);
    sync_out <= 1'b1;
    repeat (4) @(posedge clk_in);
    sync_out <= 1'b0;
    repeat (DESKEW) @(posedge clk_in);
  endtask
endmodule

// ===== sim/testbench.sv
// Self-checking bench for the digital input group
`timescale 1ns/1ns
module testbench;
  // -----------------------------
  // Stimulus and observed signals
  // -----------------------------
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awa, ara;
  logic [31:0] wd;
  logic [3:0] ws;
  logic awv, wv, br, arv, rr;
  logic awr, wr_rdy, bv, arr, rv, rdy, ordy, irq, sync;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d;
  logic [15:0] pts, lvl, pts_q;
  int err_total = 0;
  int tests_run = 0;
  int cyc = 0;
  int lag = 0;
  int n;
  // 125 MHz
  always #4 clk = ~clk;
  dig_in_group uut (.SYS_CLK_IN(clk), .RST_IN(rst), .S_AXI_AWADDR_IN(awa),
    .S_AXI_AWVALID_IN(awv), .S_AXI_AWREADY_OUT(awr), .S_AXI_WDATA_IN(wd),
    .S_AXI_WSTRB_IN(ws), .S_AXI_WVALID_IN(wv), .S_AXI_WREADY_OUT(wr_rdy),
    .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bv), .S_AXI_BREADY_IN(br),
    .S_AXI_ARADDR_IN(ara), .S_AXI_ARVALID_IN(arv), .S_AXI_ARREADY_OUT(arr),
    .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rv),
    .S_AXI_RREADY_IN(rr), .LEVEL_INPUT_IN(lvl), .SYNC_STROBE_IN(sync),
    .READY_OUT(rdy), .OUT_POINTS_OUT(pts), .OUT_READY_OUT(ordy), .IRQ_OUT(irq));
  ext_equip pe (.clk_in(clk), .ready_in(rdy), .level_out(lvl), .sync_out(sync));
  // -----------------------------
  // Checking and bus tasks
  // -----------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e)
    begin
      err_total++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic stop_test();
    if (err_total == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Write: address and data together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic aw;
    logic w;
    @(posedge clk);
    awa <= a;
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    ws <= 4'hF;
    br <= 1'b1;
    aw = 1'b1;
    w = 1'b1;
    while (aw || w)
    begin
      @(posedge clk);
      if (aw && awr === 1'b1)
      begin
        aw = 1'b0;
        awv <= 1'b0;
      end
      if (w && wr_rdy === 1'b1)
      begin
        w = 1'b0;
        wv <= 1'b0;
      end
    end
    // Response only after both were taken
    do @(posedge clk); while (bv !== 1'b1);
    rs = bresp;
    br <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 1'b0;
    do @(posedge clk); while (rv !== 1'b1);
    v = rdata;
    rs = rresp;
    rr <= 1'b0;
  endtask
  // Read and compare, response must be OKAY
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    logic [1:0] rs;
    rd(a, v, rs);
    chk(rs, dig_in_pkg::RESP_OKAY);
    chk(v, e);
  endtask
  // Command write with expected response
  task automatic cmd(input logic [3:0] c, input logic [1:0] e);
    logic [1:0] rs;
    wr(dig_in_pkg::OFF_CMD, {28'h000_0000, c}, rs);
    chk(rs, e);
  endtask
  task automatic wt(input int k);
    repeat (k) @(posedge clk);
  endtask
  // Bounded wait, irq must come within the response time
  task automatic wirq();
    n = 0;
    while (irq !== 1'b1 && n < dig_in_pkg::IRQ_MAX_CYC)
    begin
      @(posedge clk);
      n++;
    end
    chk(irq, 1);
  endtask
  // Cycles since output points last changed; hang ceiling
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    pts_q <= pts;
    lag <= (pts !== pts_q) ? 0 : lag + 1;
    if (cyc == 20000)
    begin
      err_total++;
      stop_test();
    end
  end
  // -----------------------------
  // Main sequence
  // -----------------------------
  initial
  begin
    // Bus idle before the first edge
    awa <= 8'h00;
    ara <= 8'h00;
    wd <= 32'h0000_0000;
    ws <= 4'h0;
    awv <= 1'b0;
    wv <= 1'b0;
    br <= 1'b0;
    arv <= 1'b0;
    rr <= 1'b0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rdc(dig_in_pkg::OFF_STATUS, 0);
    // Plain mode: live level and history
    pe.put(16'hA5A5);
    wt(8);
    cmd(dig_in_pkg::CMD_READ_LEVEL, dig_in_pkg::RESP_OKAY);
    rdc(dig_in_pkg::OFF_LEVEL, 32'h0000_A5A5);
    cmd(dig_in_pkg::CMD_READ_HIST, dig_in_pkg::RESP_OKAY);
    rdc(dig_in_pkg::OFF_HIST, 32'h0000_A5A5);
    // Arming clears history, falling edges stay quiet
    cmd(dig_in_pkg::CMD_ARM_TRANS, dig_in_pkg::RESP_OKAY);
    rdc(dig_in_pkg::OFF_HIST, 0);
    rdc(dig_in_pkg::OFF_STATUS, dig_in_pkg::MODE_TRANS);
    pe.put(16'h0000);
    wt(8);
    chk(irq, 0);
    pe.put(16'h0001);
    wirq();
    rdc(dig_in_pkg::OFF_HIST, 1);
    // Plain read refused while pending, irq held
    cmd(dig_in_pkg::CMD_READ_HIST, dig_in_pkg::RESP_SLVERR);
    rd(dig_in_pkg::OFF_STATUS, d, r);
    chk(d[dig_in_pkg::ST_BUSY], 1);
    chk(irq, 1);
    cmd(dig_in_pkg::CMD_READ_HIST_CLR, dig_in_pkg::RESP_OKAY);
    wt(2);
    chk(irq, 0);
    rdc(dig_in_pkg::OFF_HIST, 0);
    pe.put(16'h0003);
    wirq();
    rdc(dig_in_pkg::OFF_HIST, 2);
    cmd(dig_in_pkg::CMD_READ_HIST_CLR, dig_in_pkg::RESP_OKAY);
    // Sync handshake
    cmd(dig_in_pkg::CMD_ARM_SYNC, dig_in_pkg::RESP_OKAY);
    wt(2);
    chk(rdy, 1);
    pe.send(16'h1234);
    chk({irq, rdy}, 2'b10);
    cmd(dig_in_pkg::CMD_ARM_SYNC, dig_in_pkg::RESP_SLVERR);
    pe.put(16'hFFFF);
    wt(8);
    rdc(dig_in_pkg::OFF_LEVEL, 32'h0000_1234);
    cmd(dig_in_pkg::CMD_READ_LEVEL, dig_in_pkg::RESP_OKAY);
    wt(8);
    chk({irq, rdy}, 2'b01);
    rdc(dig_in_pkg::OFF_LEVEL, 32'h0000_FFFF);
    cmd(dig_in_pkg::CMD_ARM_TRANS, dig_in_pkg::RESP_OKAY);
    wt(2);
    chk(rdy, 0);
    cmd(dig_in_pkg::CMD_HALT, dig_in_pkg::RESP_OKAY);
    rdc(dig_in_pkg::OFF_STATUS, dig_in_pkg::MODE_PLAIN);
    // Self-test: forced ones trip the armed latch
    pe.put(16'h0000);
    wt(8);
    cmd(dig_in_pkg::CMD_ARM_TRANS, dig_in_pkg::RESP_OKAY);
    cmd(dig_in_pkg::CMD_TEST_ONES, dig_in_pkg::RESP_OKAY);
    wirq();
    rdc(dig_in_pkg::OFF_HIST, 32'h0000_FFFF);
    rdc(dig_in_pkg::OFF_LEVEL, 32'h0000_FFFF);
    cmd(dig_in_pkg::CMD_DEV_RESET, dig_in_pkg::RESP_OKAY);
    wt(2);
    chk(irq, 0);
    cmd(dig_in_pkg::CMD_TEST_ZEROS, dig_in_pkg::RESP_OKAY);
    pe.put(16'hFFFF);
    wt(8);
    rdc(dig_in_pkg::OFF_LEVEL, 0);
    rd(dig_in_pkg::OFF_STATUS, d, r);
    chk(d[dig_in_pkg::ST_DIAG], 1);
    cmd(dig_in_pkg::CMD_DEV_RESET, dig_in_pkg::RESP_OKAY);
    // Output points and their ready lag
    wr(dig_in_pkg::OFF_OUT, 32'h0000_00C3, r);
    chk(r, dig_in_pkg::RESP_OKAY);
    // Points launch at the edge where the response is seen
    wt(1);
    chk(pts, 16'h00C3);
    n = 0;
    while (ordy !== 1'b1 && n < 300)
    begin
      @(posedge clk);
      n++;
    end
    // Counter reads one short of the true lag
    chk(lag + 1 >= dig_in_pkg::RDY_LAG_CYC && lag + 1 <= dig_in_pkg::RDY_MAX_CYC, 1);
    rdc(dig_in_pkg::OFF_OUT, 32'h0000_00C3);
    // Unmapped address
    rd(8'h20, d, r);
    chk(d, 32'h0000_0000);
    chk(r, dig_in_pkg::RESP_SLVERR);
    stop_test();
  end
endmodule
